// file: bench/tb_top.sv
// bench top: apb master tasks, master write and slave address scenarios;
// assumes the wires are wire-and with pull-ups, resolved here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // clock, reset and apb
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq, ackv;
   // wires and far-side parties
   logic scl_oe_n, sda_oe_n, sda_pull, ack_en = 1'h1;
   logic tb_scl = 1'h1, tb_sda = 1'h1;
   logic [7:0] rx_byte;
   wire scl = scl_oe_n & tb_scl;
   wire sda = sda_oe_n & tb_sda & ~sda_pull;
   int fails = 0, n_compared = 0;
   always #10 core_clk = ~core_clk;
   tw_ctrl u_tw_ctrl (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
      .sda_oe_n(sda_oe_n), .irq(irq));
   tw_bus_model u_tw_bus_model (.scl(scl), .sda(sda), .ack_en(ack_en),
      .sda_pull(sda_pull), .last_byte(rx_byte));
   // ************************************************
   // tasks
   // ************************************************
   // one apb transfer; holds everything until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'h1 && k < 50);
      if (k >= 50) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk); // idle edge: psel stays low for one cycle before the next call redrives it
   endtask
   // masked byte compare
   task automatic chk(input logic [7:0] got, exp, mask);
      n_compared++;
      if ((got & mask) !== (exp & mask)) begin
         fails++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // poll status until the byte is done, bounded
   task automatic wait_done;
      int k;
      k = 0;
      do begin
         apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
         k++;
      end while (rd[7] !== 1'h1 && k < 5000);
      if (k >= 5000) fails++;
   endtask
   // two core clocks, a quarter of a 160 ns link period
   task automatic half;
      repeat (2) @(posedge core_clk);
   endtask
   // bench as a far master: start, 8 bits, sample the ack slot
   task automatic send_byte(input logic [7:0] b);
      int i;
      tb_sda <= 1'h0;
      half();
      for (i = 0; i < 9; i++) begin
         tb_scl <= 1'h0;
         half();
         tb_sda <= (i < 8) ? b[7-i] : 1'h1;
         half();
         tb_scl <= 1'h1;
         half();
         if (i == 8) ackv = sda;
         half();
      end
      tb_scl <= 1'h0;
   endtask
   // closing verdict
   task automatic give_verdict;
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      @(posedge core_clk);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], tw_pkg::STAT_RST, 8'hFF);
      apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
      chk(rd[7:0], tw_pkg::CTRL_RST, 8'hFF);
      apb(1'h0, 8'h40, 32'h0);
      chk({7'h0, err}, 8'h01, 8'hFF);
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hC0);
      apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
      chk(rd[7:0], 8'hC0, 8'hFF);
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hF0);
      repeat (10) @(posedge core_clk);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h20, 8'h20);
      apb(1'h1, tw_pkg::OFS_DATA, 32'hA4);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h00, 8'h80);
      wait_done();
      chk(rd[7:0], 8'hA2, 8'hF3);
      chk({7'h0, irq}, 8'h01, 8'hFF);
      chk(rx_byte, 8'hA4, 8'hFF);
      apb(1'h1, tw_pkg::OFS_STAT, 32'h02);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h00, 8'h02);
      chk({7'h0, irq}, 8'h00, 8'hFF);
      ack_en <= 1'h0;
      apb(1'h1, tw_pkg::OFS_DATA, 32'h5A);
      wait_done();
      chk(rd[7:0], 8'hA3, 8'hF3);
      chk(rx_byte, 8'h5A, 8'hFF);
      apb(1'h0, tw_pkg::OFS_DATA, 32'h0);
      chk(rd[7:0], 8'h00, 8'hFF);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h80, 8'h80);
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hD0);
      apb(1'h0, tw_pkg::OFS_DATA, 32'h0);
      repeat (600) @(posedge core_clk);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h00, 8'h20);
      apb(1'h1, tw_pkg::OFS_ADDR, 32'h54);
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hC0);
      send_byte(8'h55);
      chk({7'h0, ackv}, 8'h00, 8'hFF);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h66, 8'h66);
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hD0);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h00, 8'h40);
      // master select while stretching as slave is a lost arbitration
      apb(1'h1, tw_pkg::OFS_CTRL, 32'hF0);
      repeat (5) @(posedge core_clk);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h12, 8'h12);
      apb(1'h1, tw_pkg::OFS_STAT, 32'h12);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(rd[7:0], 8'h00, 8'h12);
      give_verdict();
   end
   // hang guard, well past the expected run
   initial begin
      #1000000;
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire

// file: bench/tw_bus_model.sv
// bus partner: a plain slave on the two wires that takes bytes msb first
// and may acknowledge; assumes pulled-up wires resolved in the bench.
`timescale 1ns/1ps
`default_nettype none
module tw_bus_model (
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // behaviour select
   input wire logic ack_en,
   // pull on sda, 1 = pull low
   output logic sda_pull,
   // last byte taken
   output logic [7:0] last_byte
);
   int n; // bits seen since start
   logic [7:0] sh; // shift register
   initial begin
      sda_pull = 1'h0;
      last_byte = 8'h00;
      n = 0;
      sh = 8'h00;
   end
   // start: sda falls while scl high, restart the count; wait out a
   // same-step scl fall so a data change is not taken for a start
   always @(negedge sda) begin
      #1;
      if (scl && !sda) n = 0;
   end
   // data is stable while scl is high, take it on the rise
   always @(posedge scl) begin
      if (n < 8) sh = {sh[6:0], sda};
      n = n + 1;
      if (n == 8) last_byte = sh;
   end
   // ack in the ninth slot, then release so the pull-up wins
   always @(negedge scl) begin
      if (n == 8) begin
         sda_pull = ack_en;
      end else if (n >= 9) begin
         sda_pull = 1'h0;
         n = 0;
      end
   end
endmodule
`default_nettype wire

// file: common/tw_pkg.sv
// two-wire bus controller: register map, field positions, reset values,
// timing counts and state encodings shared by the design.
// assumes a 50 MHz core clock and an apb master with 32-bit data.
//
// Operation
// - enable bit gates the byte engine; busy still tracks the bus
// - interrupt request only when irq enable set
// - master select rising generates start, master mode
// - master select falling generates stop, slave mode
// - direction bit picks transmit or receive
// - receiver acks low unless ack disable set
// - repeat start as master; reads zero
// - misplaced repeat start counts as lost arbitration
// - byte done sets complete; data access matching direction clears
// - address match sets slave flag; control write clears
// - busy set by start, cleared by stop
// - hardware sets arbitration lost; write one clears
// - slave read/write status holds calling rw bit
// - pending flag from byte, match, arbitration; w1c
// - received ack status after each sent byte
// - data write starts msb-first transmit
// - master receive read returns byte, starts next
// - transfer starts only if direction matches access
// - data reads return last received byte only
// - first byte after master entry is address
// - general call enable gates general call match
package tw_pkg;
   // ************************************************
   // register byte offsets
   // ************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00; // bus_control
   localparam logic [7:0] OFS_STAT = 8'h04; // bus_status
   localparam logic [7:0] OFS_DATA = 8'h08; // bus_data
   localparam logic [7:0] OFS_ADDR = 8'h0C; // own slave address, bits 7:1
   localparam logic [7:0] OFS_CTRL2 = 8'h10; // general call enable
   // ************************************************
   // field positions
   // ************************************************
   localparam int CTRL_EN = 7;
   localparam int CTRL_IE = 6;
   localparam int CTRL_MST = 5;
   localparam int CTRL_TX = 4;
   localparam int CTRL_ACK_DISABLE = 3;
   localparam int CTRL_REPEAT_START_REQUEST = 2;
   localparam int STAT_TCF = 7;
   localparam int STAT_ADDRESSED_AS_SLAVE_FLAG = 6;
   localparam int STAT_BUSY = 5;
   localparam int STAT_ARBITRATION_LOST_FLAG = 4;
   localparam int STAT_SRW = 2;
   localparam int STAT_IIF = 1;
   localparam int STAT_RECEIVED_ACK_STATUS = 0;
   localparam int CTRL2_GCEN = 7;
   // ************************************************
   // reset values
   // ************************************************
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h80; // complete, idle
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [7:0] GEN_CALL = 8'h00; // general call address
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_MHZ = 50;
   localparam int SCL_HALF_NS = 5000; // half scl period, least
   localparam logic [8:0] SCL_HALF_CYC =
      9'((SCL_HALF_NS * CLK_MHZ + 999) / 1000);
   // ************************************************
   // master sequencer states
   // ************************************************
   typedef enum logic [3:0] {
      M_IDLE = 4'h0, M_START = 4'h1, M_HOLD = 4'h2, M_LOW = 4'h3,
      M_HIGH = 4'h4, M_RS1 = 4'h5, M_RS2 = 4'h6, M_STOP1 = 4'h7,
      M_STOP2 = 4'h8
   } tw_mst_t;
endpackage

// file: src/tw_ctrl.sv
// two-wire bus controller: apb registers, master sequencer, slave engine.
// assumes scl/sda are open-drain wires resolved outside from the enables;
// the out pins are tied low and only the enables move.
`timescale 1ns/1ps
`default_nettype none
module tw_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // interrupt
   output logic irq
);
   // ************************************************
   // input synchronisers and bus conditions
   // ************************************************
   logic scl_s1_q, scl_s2_q, scl_p_q; // scl meta, sync, previous
   logic sda_s1_q, sda_s2_q, sda_p_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      end else begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
      end
   end
   logic start_det, stop_det, scl_rise, scl_fall;
   assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   assign scl_rise = scl_s2_q & ~scl_p_q;
   assign scl_fall = ~scl_s2_q & scl_p_q;

   // ************************************************
   // apb decode
   // ************************************************
   logic acc, wr, rd, hit;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign pready = 1'b1; // zero wait states
   always_comb begin
      if (paddr == tw_pkg::OFS_CTRL) hit = 1'b1;
      else if (paddr == tw_pkg::OFS_STAT) hit = 1'b1;
      else if (paddr == tw_pkg::OFS_DATA) hit = 1'b1;
      else if (paddr == tw_pkg::OFS_ADDR) hit = 1'b1;
      else if (paddr == tw_pkg::OFS_CTRL2) hit = 1'b1;
      else hit = 1'b0;
   end
   assign pslverr = acc & ~hit;
   logic wr_ctrl, wr_stat, wr_data, rd_data, lnch_tx, lnch_rx;
   assign wr_ctrl = wr & (paddr == tw_pkg::OFS_CTRL);
   assign wr_stat = wr & (paddr == tw_pkg::OFS_STAT);
   assign wr_data = wr & (paddr == tw_pkg::OFS_DATA);
   assign rd_data = rd & (paddr == tw_pkg::OFS_DATA);

   // ************************************************
   // control registers
   // ************************************************
   logic en_q, ie_q, mst_q, mst_p_q, tx_q, ack_disable_q, rs_q, gcen_q;
   logic [6:0] own_q; // own slave address
   logic ev_arbitration_lost_flag_q; // lost arbitration, one cycle
   assign lnch_tx = wr_data & tx_q;
   assign lnch_rx = rd_data & ~tx_q;
   // software fields; arbitration loss drops master mode without stop
   always_ff @(posedge core_clk) begin
      if (reset) begin
         en_q <= tw_pkg::CTRL_RST[tw_pkg::CTRL_EN];
         ie_q <= tw_pkg::CTRL_RST[tw_pkg::CTRL_IE];
         mst_q <= tw_pkg::CTRL_RST[tw_pkg::CTRL_MST];
         tx_q <= tw_pkg::CTRL_RST[tw_pkg::CTRL_TX];
         ack_disable_q <= tw_pkg::CTRL_RST[tw_pkg::CTRL_ACK_DISABLE];
         rs_q <= 1'b0;
         mst_p_q <= 1'b0;
         gcen_q <= 1'b0;
         own_q <= tw_pkg::ADDR_RST;
      end else begin
         mst_p_q <= mst_q;
         rs_q <= wr_ctrl & pwdata[tw_pkg::CTRL_REPEAT_START_REQUEST] & mst_q;
         if (wr_ctrl) begin
            en_q <= pwdata[tw_pkg::CTRL_EN];
            ie_q <= pwdata[tw_pkg::CTRL_IE];
            mst_q <= pwdata[tw_pkg::CTRL_MST] & pwdata[tw_pkg::CTRL_EN];
            tx_q <= pwdata[tw_pkg::CTRL_TX];
            ack_disable_q <= pwdata[tw_pkg::CTRL_ACK_DISABLE];
         end else if (ev_arbitration_lost_flag_q) begin
            mst_q <= 1'b0;
         end
         if (wr & (paddr == tw_pkg::OFS_ADDR)) own_q <= pwdata[7:1];
         if (wr & (paddr == tw_pkg::OFS_CTRL2)) begin
            gcen_q <= pwdata[tw_pkg::CTRL2_GCEN];
         end
      end
   end

   // ************************************************
   // byte engine: master sequencer and slave shifter
   // ************************************************
   tw_pkg::tw_mst_t m_st_q;
   logic [8:0] cnt_q; // half period timer
   logic [7:0] sh_q, rx_q; // shift register, last received byte
   logic [3:0] bit_q; // 0..7 data bits, 8 acknowledge
   logic m_scl_q, m_sda_q; // master pulls scl/sda low
   logic s_act_q, s_addr_q, s_hold_q, s_sda_q;
   logic srw_q, received_ack_status_q, ev_tcf_q, ev_addressed_as_slave_flag_q;
   logic lpend_q; // byte fed during the start, served at the byte gap
   logic half, go_start, s_tx, amatch;
   assign half = (cnt_q == tw_pkg::SCL_HALF_CYC);
   assign go_start = mst_q & ~mst_p_q;
   assign s_tx = ~s_addr_q & tx_q;
   assign amatch = (sh_q[7:1] == own_q) |
      (gcen_q & (sh_q == tw_pkg::GEN_CALL));
   always_ff @(posedge core_clk) begin
      if (reset || !en_q) begin
         m_st_q <= tw_pkg::M_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         bit_q <= '0;
         m_scl_q <= 1'b0;
         m_sda_q <= 1'b0;
         s_act_q <= 1'b0;
         s_addr_q <= 1'b0;
         s_hold_q <= 1'b0;
         s_sda_q <= 1'b0;
         srw_q <= tw_pkg::STAT_RST[tw_pkg::STAT_SRW];
         received_ack_status_q <= tw_pkg::STAT_RST[tw_pkg::STAT_RECEIVED_ACK_STATUS];
         ev_tcf_q <= 1'b0;
         ev_addressed_as_slave_flag_q <= 1'b0;
         ev_arbitration_lost_flag_q <= 1'b0;
         lpend_q <= 1'b0;
      end else begin
         ev_tcf_q <= 1'b0;
         ev_addressed_as_slave_flag_q <= 1'b0;
         ev_arbitration_lost_flag_q <= 1'b0;
         cnt_q <= half ? '0 : cnt_q + 9'h001;
         if (lnch_tx) sh_q <= pwdata[7:0];
         case (m_st_q)
            tw_pkg::M_IDLE: begin
               m_scl_q <= 1'b0;
               m_sda_q <= 1'b0;
               cnt_q <= '0;
               lpend_q <= 1'b0;
               if (go_start && s_hold_q) begin
                  ev_arbitration_lost_flag_q <= 1'b1; // busy as addressed slave
               end else if (go_start) begin
                  m_st_q <= tw_pkg::M_START;
                  s_act_q <= 1'b0;
               end
            end
            tw_pkg::M_START: begin
               m_sda_q <= 1'b1; // sda falls while scl high
               m_scl_q <= 1'b0;
               // software may feed the address byte before the start ends
               if (lnch_tx || lnch_rx) lpend_q <= 1'b1;
               if (half) begin
                  m_st_q <= tw_pkg::M_HOLD;
                  m_scl_q <= 1'b1;
               end
            end
            tw_pkg::M_HOLD: begin
               // scl held low until software feeds the next byte
               cnt_q <= '0;
               if (!mst_q) begin
                  m_st_q <= tw_pkg::M_STOP1;
                  m_sda_q <= 1'b1;
               end else if (rs_q) begin
                  m_st_q <= tw_pkg::M_RS1;
                  m_sda_q <= 1'b0;
               end else if (lnch_tx || lnch_rx || lpend_q) begin
                  m_st_q <= tw_pkg::M_LOW;
                  bit_q <= '0;
                  lpend_q <= 1'b0;
                  m_sda_q <= lnch_tx ? ~pwdata[7] : tx_q & ~sh_q[7];
               end
            end
            tw_pkg::M_LOW: begin
               m_scl_q <= 1'b1;
               if (half) begin
                  m_st_q <= tw_pkg::M_HIGH;
                  m_scl_q <= 1'b0;
               end
            end
            tw_pkg::M_HIGH: begin
               // wait for the wire: another device may stretch scl
               if (!scl_s2_q) cnt_q <= '0;
               if (half && bit_q != 4'h8) begin
                  if (tx_q && !m_sda_q && !sda_s2_q) begin
                     m_st_q <= tw_pkg::M_IDLE; // lost: slave, no stop
                     ev_arbitration_lost_flag_q <= 1'b1;
                  end else begin
                     sh_q <= {sh_q[6:0], sda_s2_q};
                     bit_q <= bit_q + 4'h1;
                     m_st_q <= tw_pkg::M_LOW;
                     m_scl_q <= 1'b1;
                     if (bit_q == 4'h7) begin
                        // acknowledge slot: release or ack low
                        m_sda_q <= ~tx_q & ~ack_disable_q;
                     end else begin
                        m_sda_q <= tx_q & ~sh_q[6];
                     end
                  end
               end else if (half) begin
                  if (tx_q) received_ack_status_q <= sda_s2_q;
                  else rx_q <= sh_q;
                  ev_tcf_q <= 1'b1;
                  m_st_q <= tw_pkg::M_HOLD;
                  m_scl_q <= 1'b1;
               end
            end
            tw_pkg::M_RS1: begin
               if (half) begin
                  m_st_q <= tw_pkg::M_RS2;
                  m_scl_q <= 1'b0;
               end
            end
            tw_pkg::M_RS2: begin
               if (half) m_st_q <= tw_pkg::M_START;
            end
            tw_pkg::M_STOP1: begin
               if (half) begin
                  m_st_q <= tw_pkg::M_STOP2;
                  m_scl_q <= 1'b0;
               end
            end
            tw_pkg::M_STOP2: begin
               if (half) begin
                  m_st_q <= tw_pkg::M_IDLE;
                  m_sda_q <= 1'b0; // sda rises while scl high
               end
            end
            default: m_st_q <= tw_pkg::M_IDLE;
         endcase
         // repeat start outside the byte gap is a lost arbitration
         if (rs_q && m_st_q != tw_pkg::M_HOLD) begin
            ev_arbitration_lost_flag_q <= 1'b1;
            m_st_q <= tw_pkg::M_IDLE;
         end
         // slave engine runs only while the sequencer is idle
         if (m_st_q == tw_pkg::M_IDLE && !go_start) begin
            if (start_det) begin
               s_act_q <= 1'b1;
               s_addr_q <= 1'b1;
               s_hold_q <= 1'b0;
               s_sda_q <= 1'b0;
               bit_q <= 4'hF; // the scl fall closing the start is no bit
            end else if (stop_det) begin
               s_act_q <= 1'b0;
               s_hold_q <= 1'b0;
               s_sda_q <= 1'b0;
            end else if (s_hold_q && (lnch_tx || lnch_rx)) begin
               s_hold_q <= 1'b0;
               s_sda_q <= lnch_tx & ~pwdata[7];
            end else if (s_act_q && scl_rise) begin
               if (bit_q != 4'h8) sh_q <= {sh_q[6:0], sda_s2_q};
               else if (s_tx) received_ack_status_q <= sda_s2_q;
            end else if (s_act_q && scl_fall) begin
               bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
               if (bit_q == 4'hF) begin
                  s_sda_q <= 1'b0; // start closed, first bit follows
               end else if (bit_q < 4'h7) begin
                  s_sda_q <= s_tx & ~sh_q[7];
               end else if (bit_q == 4'h7 && s_addr_q) begin
                  if (amatch) begin
                     ev_addressed_as_slave_flag_q <= 1'b1;
                     srw_q <= sh_q[0];
                     s_sda_q <= 1'b1;
                  end else begin
                     s_act_q <= 1'b0;
                  end
               end else if (bit_q == 4'h7) begin
                  if (!s_tx) rx_q <= sh_q;
                  s_sda_q <= ~s_tx & ~ack_disable_q;
               end else begin
                  // ack done: stretch scl until software answers
                  s_addr_q <= 1'b0;
                  s_sda_q <= 1'b0;
                  s_hold_q <= 1'b1;
                  ev_tcf_q <= 1'b1;
               end
            end
         end
      end
   end

   // ************************************************
   // status flags; a hardware set beats a software clear
   // ************************************************
   logic tcf_q, addressed_as_slave_flag_q, busy_q, arbitration_lost_flag_q, iif_q;
   logic tcf_clr;
   assign tcf_clr = lnch_tx | lnch_rx;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tcf_q <= tw_pkg::STAT_RST[tw_pkg::STAT_TCF];
         addressed_as_slave_flag_q <= tw_pkg::STAT_RST[tw_pkg::STAT_ADDRESSED_AS_SLAVE_FLAG];
         busy_q <= tw_pkg::STAT_RST[tw_pkg::STAT_BUSY];
         arbitration_lost_flag_q <= tw_pkg::STAT_RST[tw_pkg::STAT_ARBITRATION_LOST_FLAG];
         iif_q <= tw_pkg::STAT_RST[tw_pkg::STAT_IIF];
      end else begin
         if (ev_tcf_q) tcf_q <= 1'b1;
         else if (tcf_clr) tcf_q <= 1'b0;
         if (ev_addressed_as_slave_flag_q) addressed_as_slave_flag_q <= 1'b1;
         else if (wr_ctrl) addressed_as_slave_flag_q <= 1'b0;
         if (start_det) busy_q <= 1'b1;
         else if (stop_det) busy_q <= 1'b0;
         if (ev_arbitration_lost_flag_q) arbitration_lost_flag_q <= 1'b1;
         else if (wr_stat && pwdata[tw_pkg::STAT_ARBITRATION_LOST_FLAG]) arbitration_lost_flag_q <= 1'b0;
         if (ev_tcf_q || ev_addressed_as_slave_flag_q || ev_arbitration_lost_flag_q) iif_q <= 1'b1;
         else if (wr_stat && pwdata[tw_pkg::STAT_IIF]) iif_q <= 1'b0;
      end
   end
   assign irq = iif_q & ie_q;

   // ************************************************
   // read data, captured in the setup cycle
   // ************************************************
   logic [31:0] rdat_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdat_q <= '0;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == tw_pkg::OFS_CTRL) begin
            rdat_q <= {24'h000000, en_q, ie_q, mst_q, tx_q, ack_disable_q,
               3'h0};
         end else if (paddr == tw_pkg::OFS_STAT) begin
            rdat_q <= {24'h000000, tcf_q, addressed_as_slave_flag_q, busy_q, arbitration_lost_flag_q, 1'b0,
               srw_q, iif_q, received_ack_status_q};
         end else if (paddr == tw_pkg::OFS_DATA) begin
            rdat_q <= {24'h000000, rx_q};
         end else if (paddr == tw_pkg::OFS_ADDR) begin
            rdat_q <= {24'h000000, own_q, 1'b0};
         end else if (paddr == tw_pkg::OFS_CTRL2) begin
            rdat_q <= {24'h000000, gcen_q, 7'h00};
         end else begin
            rdat_q <= '0;
         end
      end
   end
   assign prdata = rdat_q;

   // ************************************************
   // pin drivers: open drain, enable low pulls the wire low
   // ************************************************
   logic scl_oe_n_q, sda_oe_n_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
      end else begin
         scl_oe_n_q <= ~(m_scl_q | s_hold_q);
         sda_oe_n_q <= ~(m_sda_q | s_sda_q);
      end
   end
   assign scl_oe_n = scl_oe_n_q;
   assign sda_oe_n = sda_oe_n_q;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_irq;
      iif_q && ie_q |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_off;
      !en_q ##1 !en_q |=> scl_oe_n && sda_oe_n;
   endproperty
   a_off: assert property (p_off) else $error("pins driven off");
   property p_repeat_start_request;
      rd && paddr == tw_pkg::OFS_CTRL |-> !prdata[tw_pkg::CTRL_REPEAT_START_REQUEST];
   endproperty
   a_repeat_start_request: assert property (p_repeat_start_request) else $error("repeat_start_request read 1");
   property p_tcf;
      lnch_tx && !ev_tcf_q |=> !tcf_q;
   endproperty
   a_tcf: assert property (p_tcf) else $error("tcf kept");
   property p_arbitration_lost_flag;
      wr_stat && pwdata[tw_pkg::STAT_ARBITRATION_LOST_FLAG] && !ev_arbitration_lost_flag_q |=> !arbitration_lost_flag_q;
   endproperty
   a_arbitration_lost_flag: assert property (p_arbitration_lost_flag) else $error("arbitration_lost_flag kept");
   property p_addressed_as_slave_flag;
      wr_ctrl && !ev_addressed_as_slave_flag_q |=> !addressed_as_slave_flag_q;
   endproperty
   a_addressed_as_slave_flag: assert property (p_addressed_as_slave_flag) else $error("addressed_as_slave_flag kept");
   property p_busy;
      start_det |=> busy_q;
   endproperty
   a_busy: assert property (p_busy) else $error("busy unset");
   sequence s_begin;
      go_start && m_st_q == tw_pkg::M_IDLE && !s_hold_q && en_q;
   endsequence
   property p_start;
      s_begin |-> ##[1:3] (!sda_oe_n && scl_oe_n);
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_dir;
      rd_data && tx_q && m_st_q == tw_pkg::M_HOLD && mst_q && !rs_q
         |=> m_st_q == tw_pkg::M_HOLD;
   endproperty
   a_dir: assert property (p_dir) else $error("bad launch");
   property p_pend;
      ev_tcf_q || ev_addressed_as_slave_flag_q || ev_arbitration_lost_flag_q |=> iif_q;
   endproperty
   a_pend: assert property (p_pend) else $error("iif unset");
endmodule
`default_nettype wire
